/* core/asc_defs.vh */
// Constants of the two-channel I2S and multi-slot TDM audio serial port: offsets, fields, timing
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
// ==========================================
// Register offsets (byte addresses)
`define ASC_AW          8
`define ASC_OFF_CTRL    8'h00
`define ASC_OFF_CFG     8'h04
`define ASC_OFF_STAT    8'h08
`define ASC_OFF_IEN     8'h0c
`define ASC_OFF_IDIS    8'h10
`define ASC_OFF_IMASK   8'h14
`define ASC_OFF_RHR     8'h18
`define ASC_OFF_THR     8'h1c
// ==========================================
// Control register bits (write one to act)
`define ASC_CK_EN       0
`define ASC_CK_DIS      1
`define ASC_RX_EN       2
`define ASC_RX_DIS      3
`define ASC_TX_EN       4
`define ASC_TX_DIS      5
// ==========================================
// Configuration register fields
`define ASC_CFG_RST     32'h00000000
`define ASC_CFG_MASK    32'h00ff0fdf
`define ASC_CFG_MODE    1:0
`define ASC_CFG_LEN     4:2
`define ASC_CFG_MCKSEL  6
`define ASC_CFG_TDM     7
`define ASC_CFG_NCH     10:8
`define ASC_CFG_FSW     11
`define ASC_CFG_RATIO   23:16
`define ASC_MODE_SLAVE  2'h0
`define ASC_MODE_MASTER 2'h1
`define ASC_MODE_CTRLR  2'h2
// ==========================================
// Status and interrupt bits
`define ASC_ST_RECEIVE_READY_FLAG    0
`define ASC_ST_TRANSMIT_READY_FLAG    1
`define ASC_ST_CKON     2
`define ASC_ST_RXON     3
`define ASC_ST_TXON     4
`define ASC_IRQ_W       2
// ==========================================
// Word lengths and slot timing
`define ASC_LEN_32      6'h20
`define ASC_LEN_24      6'h18
`define ASC_LEN_20      6'h14
`define ASC_LEN_18      6'h12
`define ASC_LEN_16      6'h10
`define ASC_LEN_8       6'h08
`define ASC_SLOT_LAST   5'h1f
`define ASC_SLOT_START  5'h1e
`define ASC_POS_IDLE    6'h3f
`define ASC_POS_LAST    6'h1f
`define ASC_I2S_LASTCH  3'h1
`define ASC_HALF_MIN    9'h002
`endif

/* core/asc_sync.v */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module asc_sync #(
    parameter W = 1
) (
    input  wire         sys_clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // ==========================================
    // First stage feeds only the second stage
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end
    assign q = sync_r;
endmodule
`default_nettype wire

/* core/asc_top.v */
// Two-channel I2S and multi-slot TDM audio serial port: registers, clock generator, receiver, transmitter
//
// Added by the designer: strobed register access and the address map.
`include "asc_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module asc_top (
    input  wire                  sys_clk,
    input  wire                  rst_n,
    input  wire [`ASC_AW-1:0]    addr,
    input  wire [31:0]           wdata,
    input  wire                  wr_stb,
    input  wire                  rd_stb,
    output wire [31:0]           rdata,
    output wire                  irq,
    output wire                  codec_master_clock_out,
    input  wire                  bit_clock_pin_i,
    output wire                  bit_clock_pin_o,
    output wire                  bit_clock_pin_oe,
    input  wire                  word_select_pin_i,
    output wire                  word_select_pin_o,
    output wire                  word_select_pin_oe,
    input  wire                  serial_data_in_pin,
    output wire                  serial_data_out_pin
);
    reg  [31:0] cfg_r;
    reg  [31:0] rhr_r;
    reg  [31:0] thr_r;
    reg  [31:0] rdata_r;
    reg  [31:0] rdata_nxt;
    reg  [31:0] rx_sh_r;
    reg  [31:0] tx_word_r;
    reg  [1:0]  ien_r;
    reg         ck_on_r;
    reg         rx_on_r;
    reg         tx_on_r;
    reg         ck_stop_r;
    reg         rx_stop_r;
    reg         tx_stop_r;
    reg         rx_rdy_r;
    reg         tx_full_r;
    reg         irq_r;
    reg         mck_r;
    reg         oe_r;
    reg         sdo_r;
    reg  [8:0]  div_r;
    reg         gbck_r;
    reg         gws_r;
    reg         gws_nxt;
    reg  [4:0]  gpos_r;
    reg  [2:0]  gch_r;
    reg         bck_d_r;
    reg         ws_prev_r;
    reg  [5:0]  pos_r;
    reg  [2:0]  ch_r;
    reg  [5:0]  len;
    reg  [31:0] lmask;
    wire [2:0]  pin_s;
    wire [1:0]  mode;
    wire        drive;
    wire        tdm;
    wire [2:0]  lastc;
    wire        g_tick;
    wire        g_rise;
    wire        g_fall;
    wire [4:0]  gpos_n;
    wire [2:0]  gch_n;
    wire [2:0]  gch_inc;
    wire        w_lv;
    wire        rise_ev;
    wire        fall_ev;
    wire        sync_ev;
    wire        fs_ev;
    wire        stop_ok;
    wire [31:0] rx_full;
    wire        rx_take;
    wire        rx_done;
    wire        rx_short;
    wire        rx_dlv;
    wire [5:0]  tidx;
    wire [31:0] tx_src;
    wire        wr_ctrl;
    wire        rd_rhr;
    wire        wr_thr;
    wire        tx_load;

    // ==========================================
    // Pin synchronisers: bit clock, word select, data in
    asc_sync #(
        .W (3)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({bit_clock_pin_i, word_select_pin_i, serial_data_in_pin}),
        .q       (pin_s)
    );

    assign mode  = cfg_r[`ASC_CFG_MODE];
    assign drive = (mode == `ASC_MODE_MASTER) || (mode == `ASC_MODE_CTRLR);
    assign tdm   = cfg_r[`ASC_CFG_TDM];
    assign lastc = tdm ? cfg_r[`ASC_CFG_NCH] : `ASC_I2S_LASTCH;

    // Word length code to bit count and mask; compact codes run as plain words
    always @* begin
        case (cfg_r[`ASC_CFG_LEN])
            3'h0:    len = `ASC_LEN_32;
            3'h1:    len = `ASC_LEN_24;
            3'h2:    len = `ASC_LEN_20;
            3'h3:    len = `ASC_LEN_18;
            3'h4:    len = `ASC_LEN_16;
            3'h5:    len = `ASC_LEN_16;
            default: len = `ASC_LEN_8;
        endcase
        lmask = ~(32'hffffffff << len) | ((len == `ASC_LEN_32) ? 32'hffffffff : 32'h0);
    end

    // ==========================================
    // Register bus
    assign wr_ctrl = wr_stb && (addr == `ASC_OFF_CTRL);
    assign wr_thr  = wr_stb && (addr == `ASC_OFF_THR);
    assign rd_rhr  = rd_stb && (addr == `ASC_OFF_RHR);

    always @* begin
        rdata_nxt = 32'h0;
        if (rd_stb) begin
            case (addr)
                `ASC_OFF_CFG:   rdata_nxt = cfg_r;
                `ASC_OFF_STAT:  rdata_nxt = {27'h0, tx_on_r, rx_on_r, ck_on_r,
                                             ~tx_full_r, rx_rdy_r};
                `ASC_OFF_IMASK: rdata_nxt = {30'h0, ien_r};
                `ASC_OFF_RHR:   rdata_nxt = rhr_r;
                default:        rdata_nxt = 32'h0;
            endcase
        end
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r   <= `ASC_CFG_RST;
            ien_r   <= 2'h0;
            thr_r   <= 32'h0;
            rdata_r <= 32'h0;
            irq_r   <= 1'b0;
            oe_r    <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            // Software is expected to hold the port stopped here; pins turn at once
            if (wr_stb && (addr == `ASC_OFF_CFG))
                cfg_r <= wdata & `ASC_CFG_MASK;
            if (wr_stb && (addr == `ASC_OFF_IEN))
                ien_r <= ien_r | wdata[1:0];
            else if (wr_stb && (addr == `ASC_OFF_IDIS))
                ien_r <= ien_r & ~wdata[1:0];
            if (wr_thr)
                thr_r <= wdata;
            irq_r <= |(ien_r & {~tx_full_r, rx_rdy_r});
            oe_r  <= drive;
        end
    end

    // ==========================================
    // Enable and disable of the three units
    assign stop_ok = fs_ev || (drive && !ck_on_r);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_on_r   <= 1'b0;
            rx_on_r   <= 1'b0;
            tx_on_r   <= 1'b0;
            ck_stop_r <= 1'b0;
            rx_stop_r <= 1'b0;
            tx_stop_r <= 1'b0;
        end else begin
            // Clock generator; it stops on the falling edge that ends the frame,
            // so the last high half of the bit clock is never cut short
            if (ck_stop_r && (!drive || (g_fall && gpos_r == `ASC_SLOT_LAST
                                         && gch_r == lastc))) begin
                ck_on_r   <= 1'b0;
                ck_stop_r <= 1'b0;
            end
            if (wr_ctrl && wdata[`ASC_CK_EN]) begin
                ck_on_r   <= 1'b1;
                ck_stop_r <= 1'b0;
            end
            if (wr_ctrl && wdata[`ASC_CK_DIS] && ck_on_r)
                ck_stop_r <= 1'b1;
            // Receiver
            if (rx_stop_r && stop_ok) begin
                rx_on_r   <= 1'b0;
                rx_stop_r <= 1'b0;
            end
            if (wr_ctrl && wdata[`ASC_RX_EN] && mode != `ASC_MODE_CTRLR) begin
                rx_on_r   <= 1'b1;
                rx_stop_r <= 1'b0;
            end
            if (wr_ctrl && wdata[`ASC_RX_DIS] && rx_on_r)
                rx_stop_r <= 1'b1;
            // Transmitter
            if (tx_stop_r && stop_ok) begin
                tx_on_r   <= 1'b0;
                tx_stop_r <= 1'b0;
            end
            if (wr_ctrl && wdata[`ASC_TX_EN] && mode != `ASC_MODE_CTRLR) begin
                tx_on_r   <= 1'b1;
                tx_stop_r <= 1'b0;
            end
            if (wr_ctrl && wdata[`ASC_TX_DIS] && tx_on_r)
                tx_stop_r <= 1'b1;
        end
    end

    // ==========================================
    // Clock generator for master and controller modes
    // Half bit period is ratio plus three cycles, so the late sampled data
    // input still settles before the rising edge
    assign g_tick  = ck_on_r && drive && (div_r >= ({1'b0, cfg_r[`ASC_CFG_RATIO]}
                                                    + `ASC_HALF_MIN));
    assign g_rise  = g_tick && !gbck_r;
    assign g_fall  = g_tick && gbck_r;
    assign gch_inc = (gch_r == lastc) ? 3'h0 : gch_r + 3'h1;
    assign gpos_n  = gpos_r + 5'h1;
    assign gch_n   = (gpos_r == `ASC_SLOT_LAST) ? gch_inc : gch_r;

    // Select level after a falling edge; it changes one bit before the MSB
    always @* begin
        if (!tdm)
            gws_nxt = (gpos_n == `ASC_SLOT_LAST) ?
                      ((gch_n == lastc) ? 1'b0 : gch_n[0] ^ 1'b1) : gch_n[0];
        else if (!cfg_r[`ASC_CFG_FSW])
            gws_nxt = (gpos_n == `ASC_SLOT_LAST) && (gch_n == lastc);
        else
            gws_nxt = ((gpos_n == `ASC_SLOT_LAST) && (gch_n == lastc)) ||
                      ((gpos_n != `ASC_SLOT_LAST) && (gch_n == 3'h0));
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= 9'h0;
            gbck_r <= 1'b0;
            gws_r  <= 1'b0;
            gpos_r <= `ASC_SLOT_START;
            gch_r  <= 3'h0;
            mck_r  <= 1'b0;
        end else if (!ck_on_r || !drive) begin
            div_r  <= 9'h0;
            gbck_r <= 1'b0;
            gws_r  <= !tdm;
            gpos_r <= `ASC_SLOT_START;
            gch_r  <= lastc;
            mck_r  <= 1'b0;
        end else begin
            mck_r  <= cfg_r[`ASC_CFG_MCKSEL] ? ~mck_r : 1'b0;
            div_r  <= g_tick ? 9'h0 : div_r + 9'h1;
            if (g_tick)
                gbck_r <= ~gbck_r;
            if (g_fall) begin
                gpos_r <= gpos_n;
                gch_r  <= gch_n;
                gws_r  <= gws_nxt;
            end
        end
    end

    // ==========================================
    // Slot tracker shared by receiver and transmitter
    assign w_lv    = drive ? gws_r : pin_s[1];
    assign rise_ev = drive ? g_rise : (pin_s[2] && !bck_d_r);
    assign fall_ev = drive ? g_fall : (!pin_s[2] && bck_d_r);
    assign sync_ev = rise_ev && (tdm ? (w_lv && !ws_prev_r) : (w_lv != ws_prev_r));
    assign fs_ev   = sync_ev && (tdm || !w_lv);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bck_d_r   <= 1'b0;
            ws_prev_r <= 1'b0;
            pos_r     <= `ASC_POS_IDLE;
            ch_r      <= 3'h0;
        end else begin
            bck_d_r <= pin_s[2];
            if (drive && !ck_on_r) begin
                ws_prev_r <= !tdm;
                pos_r     <= `ASC_POS_IDLE;
            end else if (rise_ev) begin
                ws_prev_r <= w_lv;
                if (sync_ev) begin
                    pos_r <= 6'h0;
                    ch_r  <= tdm ? 3'h0 : {2'h0, w_lv};
                end else if (tdm && pos_r == `ASC_POS_LAST) begin
                    pos_r <= 6'h0;
                    ch_r  <= ch_r + 3'h1;
                end else if (pos_r != `ASC_POS_IDLE) begin
                    pos_r <= pos_r + 6'h1;
                end
            end
        end
    end

    // ==========================================
    // Receiver
    assign rx_full  = {rx_sh_r[30:0], pin_s[0]};
    assign rx_take  = rise_ev && rx_on_r && (pos_r < len);
    assign rx_done  = rx_take && (pos_r == len - 6'h1);
    assign rx_short = rx_take && sync_ev && (pos_r < len - 6'h1);
    assign rx_dlv   = rx_done || rx_short;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_r  <= 32'h0;
            rhr_r    <= 32'h0;
            rx_rdy_r <= 1'b0;
        end else begin
            if (rx_take)
                rx_sh_r <= sync_ev ? 32'h0 : rx_full;
            if (rx_done)
                rhr_r <= rx_full & lmask;
            else if (rx_short)
                rhr_r <= (rx_full << (len - 6'h1 - pos_r)) & lmask;
            if (rx_dlv)
                rx_rdy_r <= 1'b1;
            else if (rd_rhr)
                rx_rdy_r <= 1'b0;
        end
    end

    // ==========================================
    // Transmitter; an empty holding register sends a zero word
    assign tx_load = fall_ev && tx_on_r && (pos_r == 6'h0);
    assign tx_src  = tx_load ? (tx_full_r ? thr_r : 32'h0) : tx_word_r;
    assign tidx    = len - 6'h1 - pos_r;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_word_r <= 32'h0;
            tx_full_r <= 1'b0;
            sdo_r     <= 1'b0;
        end else begin
            if (tx_load)
                tx_word_r <= tx_src;
            if (wr_thr)
                tx_full_r <= 1'b1;
            else if (tx_load)
                tx_full_r <= 1'b0;
            // Shift on the falling edge, MSB first, zeros past the word
            if (fall_ev)
                sdo_r <= (tx_on_r && pos_r < len) ? tx_src[tidx[4:0]] : 1'b0;
        end
    end

    // ==========================================
    // Outputs; with the clock unit off in master or controller mode the generator and the slot tracker's position and select history return to their start values
    assign rdata                  = rdata_r;
    assign irq                    = irq_r;
    assign codec_master_clock_out = mck_r;
    assign bit_clock_pin_o        = gbck_r;
    assign bit_clock_pin_oe       = oe_r;
    assign word_select_pin_o      = gws_r;
    assign word_select_pin_oe     = oe_r;
    assign serial_data_out_pin    = sdo_r;
endmodule
`default_nettype wire

/* bench/asc_codec_model.sv */
// Behavioural audio codec on the far side of the serial link
`timescale 1ns/100ps
`default_nettype none
module asc_codec_model (
    input  wire logic bclk,
    input  wire logic ws,
    input  wire logic sdo,
    input  wire logic drv,
    output var logic  sdi,
    output var logic  bclk_o,
    output var logic  ws_o
);
    logic [31:0] sh;
    logic [31:0] cur;
    logic [31:0] snd[$];
    logic [31:0] got[$];
    logic        lw;
    logic        started;
    int          pos;
    int          nfall;
    initial begin
        sdi = 1'b0;
        bclk_o = 1'b0;
        ws_o = 1'b0;
        sh = 32'h0;
        cur = 32'h0;
        lw = 1'bx;
        started = 1'b0;
        pos = 0;
        nfall = 0;
    end
    // ==========================================
    // Clock source for slave operation; stands still while drv is low
    always begin
        #62.5;
        if (drv) begin
            bclk_o = ~bclk_o;
            if (!bclk_o) begin
                nfall = nfall + 1;
                if (nfall % 32 == 0) ws_o = ~ws_o;
            end
        end
    end
    // ==========================================
    // Capture; a select change seen at a rise closes the slot, so zero slots are dropped
    always @(posedge bclk) begin
        sh = {sh[30:0], sdo};
        pos = pos + 1;
        if (ws !== lw) begin
            if (started && sh != 32'h0) got.push_back(sh);
            started = 1'b1;
            pos = 0;
            sh = 32'h0;
            lw = ws;
        end
    end
    // Outside a slot the line toggles so a stale bit cannot pass for data
    always @(negedge bclk) begin
        if (pos == 0) cur = (started && snd.size() > 0) ? snd.pop_front() : 32'h0;
        sdi = (pos < 32) ? cur[31 - pos] : ~sdi;
    end
endmodule
`default_nettype wire

/* bench/asc_assertions.sv */
// Concurrent checks on the pins of the audio serial port
`timescale 1ns/100ps
`default_nettype none
`include "asc_defs.vh"
module asc_assertions (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [31:0] rdata,
    input wire logic        irq,
    input wire logic        codec_master_clock_out,
    input wire logic        bit_clock_pin_o,
    input wire logic        bit_clock_pin_oe,
    input wire logic        word_select_pin_o,
    input wire logic        word_select_pin_oe,
    input wire logic        serial_data_out_pin
);
    logic [31:0] cfg_r;
    logic [1:0]  mask_r;
    // ==========================================
    // Shadow of configuration and interrupt mask, taken from bus writes
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= 32'h0;
            mask_r <= 2'h0;
        end else if (wr_stb) begin
            if (addr == `ASC_OFF_CFG) cfg_r <= wdata & `ASC_CFG_MASK;
            if (addr == `ASC_OFF_IEN) mask_r <= mask_r | wdata[1:0];
            if (addr == `ASC_OFF_IDIS) mask_r <= mask_r & ~wdata[1:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Properties
    property p_oe_pair; bit_clock_pin_oe == word_select_pin_oe; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("pin enables differ");
    // Two cycles of settled configuration before the direction is judged
    property p_oe_mode;
        cfg_r == $past(cfg_r, 2) |-> bit_clock_pin_oe == (cfg_r[1:0] != `ASC_MODE_SLAVE);
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("pin direction wrong");
    property p_ctrl_zero; rd_stb && addr == `ASC_OFF_CTRL |=> rdata == 32'h0; endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("control read not zero");
    property p_mck_sel; !cfg_r[6] && !$past(cfg_r[6]) |-> !codec_master_clock_out; endproperty
    a_mck_sel: assert property (p_mck_sel) else $error("master clock unselected");
    property p_mck_tog; codec_master_clock_out |=> !codec_master_clock_out; endproperty
    a_mck_tog: assert property (p_mck_tog) else $error("master clock stuck");
    property p_bclk_half;
        bit_clock_pin_oe && $changed(bit_clock_pin_o) |=> $stable(bit_clock_pin_o) [*2];
    endproperty
    a_bclk_half: assert property (p_bclk_half) else $error("bit clock half too short");
    property p_sdo_fall;
        bit_clock_pin_oe && $changed(serial_data_out_pin) |-> !bit_clock_pin_o;
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("data moved while clock high");
    property p_ws_fall;
        word_select_pin_oe && $changed(word_select_pin_o) |-> !bit_clock_pin_o;
    endproperty
    a_ws_fall: assert property (p_ws_fall) else $error("select moved while clock high");
    property p_irq_off; mask_r == 2'h0 && $past(mask_r) == 2'h0 |-> !irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while masked");
endmodule
bind asc_top asc_assertions u_chk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .irq(irq),
    .codec_master_clock_out(codec_master_clock_out),
    .bit_clock_pin_o(bit_clock_pin_o),
    .bit_clock_pin_oe(bit_clock_pin_oe),
    .word_select_pin_o(word_select_pin_o),
    .word_select_pin_oe(word_select_pin_oe),
    .serial_data_out_pin(serial_data_out_pin)
);
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench: registers, modes and sample exchange with a codec model
`timescale 1ns/100ps
`default_nettype none
`include "asc_defs.vh"
module tb_top;
    logic        sys_clk, rst_n, wr_stb, rd_stb, drv, m0;
    logic [7:0]  addr;
    logic [31:0] wdata, rv, e;
    logic [31:0] txd[4];
    logic [31:0] rxw[4];
    wire  [31:0] rdata;
    wire         irq, mck, bco, bco_oe, wso, wso_oe, sdi, sdo, m_bclk, m_ws;
    wire         bclk = bco_oe ? bco : m_bclk;
    wire         ws = wso_oe ? wso : m_ws;
    int          bad_count, n_compared, c, k, nt, nr, len;
    int          lens[8] = '{32, 24, 20, 18, 16, 16, 8, 8};
    asc_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
        .codec_master_clock_out(mck), .bit_clock_pin_i(bclk), .bit_clock_pin_o(bco),
        .bit_clock_pin_oe(bco_oe), .word_select_pin_i(ws), .word_select_pin_o(wso),
        .word_select_pin_oe(wso_oe), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo));
    asc_codec_model codec (.bclk(bclk), .ws(ws), .sdo(sdo), .drv(drv), .sdi(sdi),
        .bclk_o(m_bclk), .ws_o(m_ws));
    always #4 sys_clk = ~sys_clk;
    // ==========================================
    // Bus and checking tasks
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 rv = rdata;
    endtask
    // Stopping waits for the frame in progress; the poll gives up after 2000 status reads
    task stop_all;
        wr(`ASC_OFF_CTRL, 32'h2a);
        for (k = 0; k < 2000; k++) begin
            rd(`ASC_OFF_STAT);
            if (rv[4:2] == 3'h0) break;
        end
        chk({29'h0, rv[4:2]}, 32'h0);
    endtask
    task end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #720000;
        bad_count++;
        end_of_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        drv = 1'b0;
        bad_count = 0;
        n_compared = 0;
        rv = $urandom(32'h5b97);
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        wr(`ASC_OFF_CTRL, 32'h0);
        rd(`ASC_OFF_STAT);
        chk(rv, 32'h2);
        rd(`ASC_OFF_CTRL);
        chk(rv, 32'h0);
        rd(8'h3c);
        chk(rv, 32'h0);
        $display("reset values done");
        wr(`ASC_OFF_IEN, 32'h1);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        wr(`ASC_OFF_IEN, 32'h2);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        wr(`ASC_OFF_IDIS, 32'h3);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt done");
        wr(`ASC_OFF_CFG, 32'h2);
        wr(`ASC_OFF_CTRL, 32'h15);
        rd(`ASC_OFF_STAT);
        chk({29'h0, rv[4:2]}, 32'h1);
        chk({31'h0, bco_oe}, 32'h1);
        tick(300);
        stop_all();
        $display("controller mode done");
        // Odd passes run in slave operation with the codec making the clocks
        for (c = 0; c < 8; c++) begin
            len = lens[c];
            drv <= c[0];
            wr(`ASC_OFF_CFG, (($urandom % 4) << 16) | (c[0] ? 0 : 32'h41) | (c << 2));
            wr(`ASC_OFF_CTRL, 32'h15);
            wr(`ASC_OFF_CTRL, 32'h0);
            rd(`ASC_OFF_STAT);
            chk({27'h0, rv[4:2], 2'h0}, 32'h1c);
            chk({31'h0, bco_oe}, {31'h0, ~c[0]});
            for (k = 0; k < 4; k++) begin
                txd[k] = $urandom | (32'h1 << (len - 1));
                rxw[k] = $urandom | 32'h80000000;
            end
            tick(1100);
            for (k = 0; k < 4; k++) codec.snd.push_back(rxw[k]);
            nt = 0;
            nr = 0;
            for (k = 0; k < 3000 && (nt < 4 || nr < 4); k++) begin
                rd(`ASC_OFF_STAT);
                if (rv[1] && nt < 4) begin
                    wr(`ASC_OFF_THR, txd[nt]);
                    nt++;
                end
                if (rv[0]) begin
                    rd(`ASC_OFF_RHR);
                    if (rv != 32'h0 && nr < 4) begin
                        chk(rv, rxw[nr] >> (32 - len));
                        nr++;
                        rd(`ASC_OFF_STAT);
                        chk({31'h0, rv[0]}, 32'h0);
                    end
                end
            end
            chk(32'(nr), 32'h4);
            for (k = 0; k < 4000 && codec.got.size() < 4; k++) tick(1);
            chk(32'(codec.got.size()), 32'h4);
            for (k = 0; k < 4; k++) begin
                e = txd[k] << (32 - len);
                chk(codec.got.pop_front(), e);
            end
            if (!c[0]) begin
                tick(1);
                m0 = mck;
                tick(1);
                chk({31'h0, mck}, {31'h0, ~m0});
            end
            stop_all();
            $display("word length %0d done", len);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
